// *** rtl/lfc_pkg.sv ***
// constants, types and register map of the linear flash card host controller
// Summary of operation
// [RULE1] card data bus is 16 bits: even low byte lane, odd high byte lane
// [RULE2] even lane enable gates bits 7..0, odd lane enable gates bits 15..8
// [RULE3] read only with output enable low, write enable high, a lane enabled
// [RULE4] write only with write enable low, output enable high, a lane enabled
// [RULE5] card captures address and data on write enable rising edge
// [RULE6] word address bits 1..24 pick one word of up to 16M words
// [RULE7] smaller cards ignore top address bits 24 and 23
// [RULE8] writing ffh anywhere returns the card to array read mode
// [RULE9] after 90h, reads at identifier addresses return identifier data
// [RULE10] after 70h, the next read anywhere returns the status value
// [RULE11] program: 40h or 10h at target, then data at same target
// [RULE12] erase: 20h then d0h, both inside the target block
// [RULE13] erase unit is one 128 kilobyte block, nothing outside changes
// [RULE14] b0h suspends and d0h resumes an erase or program
// [RULE15] status bit 7 is 1 when ready, 0 while busy
// [RULE16] toggling output enable high then low refreshes the status value
// [RULE17] during erase, output enable low shows status at any address
// [RULE18] status bit 3 flags a programming voltage error
// [RULE19] status bit 1 flags an operation on a locked block
// [RULE20] status bit 4 flags a failed program
// [RULE21] error bits stay set until clear status command 50h
// [RULE22] host clears status after a detected error before retrying
// [RULE23] host issues erase confirm right after erase setup
// [RULE24] card powers up in array read mode
// [RULE25] invalid write cycles leave the array unchanged
package lfc_pkg;
	localparam int CLK_MHZ     = 250;
	localparam int SYNC_STAGES = 2;
	localparam int T_WP_NS     = 60;
	localparam int T_WP_CYC    = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WPH_NS    = 30;
	localparam int T_WREC_NS   = 35;
	localparam int T_WHI_NS    = (T_WREC_NS > T_WPH_NS) ? T_WREC_NS : T_WPH_NS;
	localparam int T_WHI_CYC   = (T_WHI_NS * CLK_MHZ + 999) / 1000;
	localparam int T_ACC_NS    = 75;
	localparam int T_ACC_CYC   = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
	localparam int T_OEH_NS    = 15;
	localparam int T_OEH_CYC   = (T_OEH_NS * CLK_MHZ + 999) / 1000;

	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_ADDR  = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STAT  = 8'h10;

	localparam int CTRL_OP_LSB      = 0;
	localparam int CTRL_LANE_LSB    = 4;
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_ERR_BIT     = 1;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int STAT_PRESENT_BIT = 3;
	localparam int STAT_SR_LSB      = 8;
	localparam logic [1:0] LANES_RST = 2'h3;

	localparam logic [7:0] CODE_READ_ARRAY = 8'hff;
	localparam logic [7:0] CODE_IDENT      = 8'h90;
	localparam logic [7:0] CODE_STATUS     = 8'h70;
	localparam logic [7:0] CODE_CLEAR      = 8'h50;
	localparam logic [7:0] CODE_ERASE      = 8'h20;
	localparam logic [7:0] CODE_CONFIRM    = 8'hd0;
	localparam logic [7:0] CODE_PROGRAM    = 8'h40;
	localparam logic [7:0] CODE_SUSPEND    = 8'hb0;
	localparam logic [7:0] CODE_RESUME     = 8'hd0;

	localparam int SR_READY_BIT = 7;
	localparam logic [7:0] SR_ERR_MASK = 8'h1a;

	typedef enum logic [3:0] {
		OP_READ_ARRAY = 4'h0, OP_IDENT   = 4'h1, OP_STATUS  = 4'h2,
		OP_CLEAR      = 4'h3, OP_ERASE   = 4'h4, OP_PROGRAM = 4'h5,
		OP_SUSPEND    = 4'h6, OP_RESUME  = 4'h7, OP_READ    = 4'h8,
		OP_POLL       = 4'h9
	} lfc_op_t;

	typedef enum logic [1:0] {
		SEC_NONE = 2'h0, SEC_READ = 2'h1, SEC_DATA = 2'h2, SEC_CONFIRM = 2'h3
	} lfc_second_t;

	typedef enum logic [2:0] {
		STEP_FIRST = 3'b001, STEP_SECOND = 3'b010, STEP_POLL = 3'b100
	} lfc_step_t;

	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001, S_SETUP = 6'b000010, S_WLOW = 6'b000100,
		S_WHIGH = 6'b001000, S_RLOW  = 6'b010000, S_RHIGH = 6'b100000
	} lfc_state_t;

	typedef struct packed {
		logic        valid;
		logic        first_wr;
		logic [7:0]  code;
		lfc_second_t second;
		logic        poll;
		logic        guarded;
		logic        sr_rd;
		logic        clears;
	} lfc_plan_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] dout;
		logic [1:0]  dout_en;
		logic        oe_n;
		logic        we_n;
		logic        odd_lane_enable_n;
		logic        even_lane_enable_n;
	} lfc_pins_t;
endpackage : lfc_pkg

// *** rtl/lfc_host.sv ***
// host-side controller driving the linear flash card pins from a register port
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module lfc_host
	import lfc_pkg::*;
#(
	parameter int CARD_ADDR_BITS = 24
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic      [31:0] sw_rdata,
	output lfc_pins_t        pins,
	input  wire logic [15:0] data_in,
	input  wire logic        insert_detect_a_n,
	input  wire logic        insert_detect_b_n
);
	lfc_state_t  state_reg;
	lfc_step_t   step_reg;
	lfc_step_t   nstep;
	lfc_plan_t   plan_reg;
	lfc_plan_t   req_plan;
	lfc_plan_t   launch_plan;
	lfc_step_t   launch_step;
	lfc_step_t   start_step;
	logic [7:0]  cnt_reg;
	logic [3:0]  op_reg;
	logic [1:0]  lanes_reg;
	logic [23:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [23:0] cyc_addr_reg;
	logic [15:0] cyc_wdata_reg;
	logic [15:0] dout_reg;
	logic [15:0] rdata_reg;
	logic [15:0] sr_reg;
	logic        ready_reg;
	logic        err_reg;
	logic        refused_reg;
	logic [17:0] in_meta_reg;
	logic [17:0] in_sync_reg;
	logic        ctrl_wr;
	logic        accept;
	logic        fin;
	logic        launch;
	logic        launch_wr;
	logic        cyc_end;
	logic        sample;
	logic [15:0] lane_data;
	logic        err_hit;
	logic [1:0]  req_lanes;

	function automatic lfc_plan_t plan_of(input logic [3:0] op);
		lfc_plan_t p;
		p = '0;
		p.valid = 1'b1;
		p.first_wr = 1'b1;
		case (op)
			OP_READ_ARRAY: p.code = CODE_READ_ARRAY; // RULE8 RULE24
			OP_IDENT: begin
				p.code = CODE_IDENT; // RULE9
				p.second = SEC_READ;
			end
			OP_STATUS: begin
				p.code = CODE_STATUS; // RULE10
				p.second = SEC_READ;
				p.sr_rd = 1'b1;
			end
			OP_CLEAR: begin
				p.code = CODE_CLEAR; // RULE21
				p.clears = 1'b1;
			end
			OP_ERASE: begin
				p.code = CODE_ERASE; // RULE12 RULE13
				p.second = SEC_CONFIRM; // RULE23
				p.poll = 1'b1; // RULE17
				p.guarded = 1'b1;
			end
			OP_PROGRAM: begin
				p.code = CODE_PROGRAM; // RULE11
				p.second = SEC_DATA;
				p.poll = 1'b1;
				p.guarded = 1'b1;
			end
			OP_SUSPEND: p.code = CODE_SUSPEND; // RULE14
			OP_RESUME: p.code = CODE_RESUME; // RULE14
			OP_READ: begin
				p.first_wr = 1'b0;
				p.second = SEC_READ;
			end
			OP_POLL: begin
				p.first_wr = 1'b0;
				p.poll = 1'b1;
			end
			default: p.valid = 1'b0; // RULE25
		endcase
		return p;
	endfunction : plan_of

	function automatic logic is_write(input lfc_plan_t p, input lfc_step_t s);
		return (s == STEP_FIRST) ||
			(s == STEP_SECOND && (p.second == SEC_DATA || p.second == SEC_CONFIRM));
	endfunction : is_write

	// pins pass two flops; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			in_meta_reg <= '0;
			in_sync_reg <= '0;
		end else begin
			in_meta_reg <= {insert_detect_b_n, insert_detect_a_n, data_in};
			in_sync_reg <= in_meta_reg;
		end
	end

	assign ctrl_wr = sw_wr && sw_addr == REG_CTRL;
	assign req_plan = plan_of(sw_wdata[CTRL_OP_LSB +: 4]);
	assign req_lanes = sw_wdata[CTRL_LANE_LSB +: 2];
	// a guarded op is refused while the error flag is set
	assign accept = ctrl_wr && state_reg == S_IDLE && req_plan.valid &&
		req_lanes != 2'h0 && !(req_plan.guarded && err_reg); // RULE22 RULE3 RULE4
	assign start_step = req_plan.first_wr ? STEP_FIRST :
		(req_plan.second != SEC_NONE ? STEP_SECOND : STEP_POLL);
	assign cyc_end = (state_reg == S_WHIGH || state_reg == S_RHIGH) && cnt_reg == 8'h00;
	assign sample = state_reg == S_RLOW && cnt_reg == 8'h00;

	always_comb begin
		nstep = step_reg;
		fin = 1'b0;
		unique case (step_reg)
			STEP_FIRST: begin
				if (plan_reg.second != SEC_NONE) begin
					nstep = STEP_SECOND;
				end else if (plan_reg.poll) begin
					nstep = STEP_POLL;
				end else begin
					fin = 1'b1;
				end
			end
			STEP_SECOND: begin
				if (plan_reg.poll) begin
					nstep = STEP_POLL;
				end else begin
					fin = 1'b1;
				end
			end
			STEP_POLL: fin = ready_reg; // RULE15 RULE16
			default: fin = 1'b1;
		endcase
	end

	assign launch = (state_reg == S_IDLE && accept) || (cyc_end && !fin);
	assign launch_plan = (state_reg == S_IDLE) ? req_plan : plan_reg;
	assign launch_step = (state_reg == S_IDLE) ? start_step : nstep;
	assign launch_wr = is_write(launch_plan, launch_step);

	// bus cycle sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			step_reg <= STEP_FIRST;
			cnt_reg <= 8'h00;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					if (launch) begin
						step_reg <= launch_step;
						state_reg <= launch_wr ? S_SETUP : S_RLOW;
						cnt_reg <= launch_wr ? 8'h00 : 8'(T_ACC_CYC - 1);
					end
				end
				S_SETUP: begin
					state_reg <= S_WLOW;
					cnt_reg <= 8'(T_WP_CYC - 1);
				end
				S_WLOW: begin
					if (cnt_reg == 8'h00) begin
						state_reg <= S_WHIGH; // RULE5
						cnt_reg <= 8'(T_WHI_CYC - 1);
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				S_RLOW: begin
					if (cnt_reg == 8'h00) begin
						state_reg <= S_RHIGH; // RULE16
						cnt_reg <= 8'(T_OEH_CYC - 1);
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				S_WHIGH, S_RHIGH: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else if (fin) begin
						state_reg <= S_IDLE;
					end else begin
						step_reg <= launch_step;
						state_reg <= launch_wr ? S_SETUP : S_RLOW;
						cnt_reg <= launch_wr ? 8'h00 : 8'(T_ACC_CYC - 1);
					end
				end
			endcase
		end
	end

	// operation latched at start so software may stage the next one
	always_ff @(posedge clk) begin
		if (rst) begin
			plan_reg <= '0;
			op_reg <= 4'h0;
			lanes_reg <= LANES_RST;
			cyc_addr_reg <= 24'h000000;
			cyc_wdata_reg <= 16'h0000;
		end else if (accept) begin
			plan_reg <= req_plan;
			op_reg <= sw_wdata[CTRL_OP_LSB +: 4];
			lanes_reg <= req_lanes;
			// bits the card lacks are driven low rather than left to wander
			cyc_addr_reg <= addr_reg & 24'((32'h1 << CARD_ADDR_BITS) - 32'h1); // RULE7 RULE6
			cyc_wdata_reg <= wdata_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			addr_reg <= 24'h000000;
			wdata_reg <= 16'h0000;
		end else if (sw_wr) begin
			if (sw_addr == REG_ADDR) begin
				addr_reg <= sw_wdata[23:0];
			end
			if (sw_addr == REG_WDATA) begin
				wdata_reg <= sw_wdata[15:0];
			end
		end
	end

	// commands are copied to both byte lanes so each enabled lane chip sees them
	always_ff @(posedge clk) begin
		if (rst) begin
			dout_reg <= 16'h0000;
		end else if (launch && launch_wr) begin
			if (launch_step == STEP_FIRST) begin
				dout_reg <= {launch_plan.code, launch_plan.code};
			end else if (launch_plan.second == SEC_DATA) begin
				dout_reg <= (state_reg == S_IDLE) ? wdata_reg : cyc_wdata_reg;
			end else begin
				dout_reg <= {CODE_CONFIRM, CODE_CONFIRM};
			end
		end
	end

	assign lane_data = in_sync_reg[15:0] &
		{{8{lanes_reg[1]}}, {8{lanes_reg[0]}}}; // RULE2
	assign err_hit = |(lane_data & {SR_ERR_MASK, SR_ERR_MASK}); // RULE18 RULE19 RULE20

	// data captured at the end of the access window, sync delay included
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= 16'h0000;
			sr_reg <= 16'h0000;
			ready_reg <= 1'b0;
		end else if (sample) begin
			rdata_reg <= lane_data; // RULE1
			if (step_reg == STEP_POLL || plan_reg.sr_rd) begin
				sr_reg <= lane_data;
				ready_reg <= (!lanes_reg[0] || lane_data[SR_READY_BIT]) &&
					(!lanes_reg[1] || lane_data[8 + SR_READY_BIT]); // RULE15
			end
		end
	end

	// error flag: a new error wins over the clear
	always_ff @(posedge clk) begin
		if (rst) begin
			err_reg <= 1'b0;
		end else if (sample && (step_reg == STEP_POLL || plan_reg.sr_rd) && err_hit) begin
			err_reg <= 1'b1; // RULE21
		end else if (cyc_end && fin && plan_reg.clears) begin
			err_reg <= 1'b0; // RULE22
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			refused_reg <= 1'b0;
		end else if (ctrl_wr) begin
			refused_reg <= !accept;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sw_rdata <= 32'h00000000;
		end else if (sw_rd) begin
			sw_rdata <= 32'h00000000;
			unique case (sw_addr)
				REG_CTRL: begin
					sw_rdata[CTRL_OP_LSB +: 4] <= op_reg;
					sw_rdata[CTRL_LANE_LSB +: 2] <= lanes_reg;
				end
				REG_ADDR: sw_rdata[23:0] <= addr_reg;
				REG_WDATA: sw_rdata[15:0] <= wdata_reg;
				REG_RDATA: sw_rdata[15:0] <= rdata_reg;
				REG_STAT: begin
					sw_rdata[STAT_BUSY_BIT] <= state_reg != S_IDLE;
					sw_rdata[STAT_ERR_BIT] <= err_reg;
					sw_rdata[STAT_REFUSED_BIT] <= refused_reg;
					sw_rdata[STAT_PRESENT_BIT] <= ~|in_sync_reg[17:16];
					sw_rdata[STAT_SR_LSB +: 16] <= sr_reg;
				end
				default: sw_rdata <= 32'h00000000;
			endcase
		end
	end

	// lanes float in idle, which the card treats as standby
	always_comb begin
		pins.addr = cyc_addr_reg;
		pins.dout = dout_reg;
		pins.oe_n = state_reg != S_RLOW; // RULE3
		pins.we_n = state_reg != S_WLOW; // RULE4
		pins.even_lane_enable_n = state_reg == S_IDLE || !lanes_reg[0];
		pins.odd_lane_enable_n = state_reg == S_IDLE || !lanes_reg[1];
		pins.dout_en = (state_reg == S_SETUP || state_reg == S_WLOW ||
			state_reg == S_WHIGH) ? lanes_reg : 2'h0; // RULE2 RULE5
	end
endmodule : lfc_host

// *** sim/lfc_host_chk_sva.sv ***
// assertions on the card pins and register port of the host controller
`timescale 1ns/1ps
module lfc_host_chk
	import lfc_pkg::*;
#(
	parameter int CARD_ADDR_BITS = 24
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  sw_addr,
	input wire logic        sw_rd,
	input wire logic [31:0] sw_rdata,
	input wire lfc_pins_t   pins
);
	logic [1:0] en;
	assign en = ~{pins.odd_lane_enable_n, pins.even_lane_enable_n};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	rw_excl_a: assert property (pins.oe_n || pins.we_n)
		else $error("read and write strobes low together");
	lane_sel_a: assert property (!(pins.oe_n && pins.we_n) |-> en != 2'h0)
		else $error("strobe low with no lane enabled");
	drv_off_a: assert property (!pins.oe_n |-> pins.dout_en == 2'h0)
		else $error("host drives data during a read");
	drv_lane_a: assert property ((pins.dout_en & ~en) == 2'h0)
		else $error("data driven on a disabled lane");
	cap_hold_a: assert property ($rose(pins.we_n) |-> $stable(pins.addr) &&
		$stable(pins.dout) && pins.dout_en == en)
		else $error("address or data moved at write capture");
	we_width_a: assert property ($fell(pins.we_n) |-> ##15 $rose(pins.we_n))
		else $error("write pulse width wrong");
	oe_width_a: assert property ($fell(pins.oe_n) |-> ##21 $rose(pins.oe_n))
		else $error("read pulse width wrong");
	oe_gap_a: assert property ($rose(pins.oe_n) |-> pins.oe_n [*4])
		else $error("output enable high time too short");
	wr_rec_a: assert property ($rose(pins.we_n) |-> pins.oe_n [*8])
		else $error("read follows write too soon");
	addr_top_a: assert property ((pins.addr >> CARD_ADDR_BITS) == 24'h0)
		else $error("unused top address bit driven");
	unmapped_rd_a: assert property (sw_rd && sw_addr > REG_STAT |=> sw_rdata == 32'h0)
		else $error("unmapped read not zero");
	cover property ($rose(pins.we_n) && en == 2'h1);
	cover property ($fell(pins.oe_n) && en == 2'h3);
	cover property (sw_rd && sw_addr == REG_STAT);
endmodule : lfc_host_chk
bind lfc_host lfc_host_chk #(.CARD_ADDR_BITS(CARD_ADDR_BITS)) chk_u (.clk(clk), .rst(rst),
	.sw_addr(sw_addr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pins(pins));

// *** sim/lfc_card_model.sv ***
// behavioural flash card on the far side of the pins
`timescale 1ns/1ps
module lfc_card_model
	import lfc_pkg::*;
#(
	parameter int         ADDR_BITS = 23,
	parameter logic [7:0] MAKER_ID  = 8'h3c // arbitrary
) (
	input  wire logic        clk,
	input  wire lfc_pins_t   pins,
	input  wire logic [15:0] bus,
	input  wire logic [1:0]  fault_sel,
	input  wire logic [7:0]  busy_len,
	output logic      [15:0] card_q,
	output logic      [1:0]  card_en,
	output logic      [7:0]  last_code
);
	logic [15:0] mem [int];
	logic [7:0]  sr = 8'h80;
	logic [1:0]  mode = 2'h0;
	logic        parm = 0, earm = 0, halted = 0, we_q = 1;
	int          busy = 0, rd_cnt = 0, q[$];
	logic [1:0]  lanes;
	logic [7:0]  code;
	logic [23:0] a;
	assign lanes = ~{pins.odd_lane_enable_n, pins.even_lane_enable_n};
	assign code = lanes[0] ? bus[7:0] : bus[15:8];
	assign card_en = (!pins.oe_n && pins.we_n) ? lanes : 2'h0;
	assign a = pins.addr & ((24'h1 << ADDR_BITS) - 24'h1);
	function automatic logic [15:0] rdw(input logic [23:0] k);
		return mem.exists(k) ? mem[k] : 16'hffff;
	endfunction : rdw
	always @(posedge clk) begin
		we_q <= pins.we_n;
		rd_cnt <= (card_en != 2'h0) ? rd_cnt + 1 : 0;
		if (busy > 0 && !halted) busy = busy - 1;
		if (pins.we_n && !we_q && lanes != 2'h0) begin
			last_code <= code;
			if (parm) begin
				case (fault_sel)
				2'h1: sr[4] = 1'b1;
				2'h2: sr[3] = 1'b1;
				2'h3: sr[1] = 1'b1;
				default: mem[a] = rdw(a) & {lanes[1] ? bus[15:8] : 8'hff, lanes[0] ? bus[7:0] : 8'hff};
				endcase
				busy = busy_len;
			end else if (earm && code == CODE_CONFIRM) begin
				q.delete();
				foreach (mem[k]) if ((k >> 16) == int'(a >> 16)) q.push_back(k);
				foreach (q[i]) mem.delete(q[i]);
				busy = busy_len;
			end else begin
				case (code)
				8'hff: mode = 2'h0;
				8'h90: mode = 2'h1;
				8'h70: mode = 2'h2;
				8'h50: sr = 8'h80;
				8'hb0: halted = busy > 0;
				8'hd0: halted = 1'b0;
				default: ;
				endcase
			end
			if (parm || earm) mode = 2'h2;
			parm <= !parm && !earm && (code == 8'h40 || code == 8'h10);
			earm <= !parm && !earm && code == 8'h20;
		end
		// output is junk until the access time has run out
		if (rd_cnt < 16) card_q <= {2{rd_cnt[7:0] ^ 8'h5a}};
		else if (mode == 2'h2 || busy > 0) card_q <= {2{busy == 0, sr[6:0]}};
		else if (mode == 2'h1) card_q <= {2{a == 24'h0 ? MAKER_ID : ~MAKER_ID}};
		else card_q <= rdw(a);
	end
endmodule : lfc_card_model

// *** sim/linear_flash_card_command_port_test.sv ***
// self-checking bench for the flash card host controller
`timescale 1ns/1ps
module linear_flash_card_command_port_test
	import lfc_pkg::*;
;
	localparam logic [7:0] MAKER = 8'h3c; // arbitrary
	logic        clk = 0, rst = 1, sw_wr = 0, sw_rd = 0, det_n = 0;
	logic [7:0]  sw_addr = 8'h0, busy_len = 8'h14, last_code;
	logic [31:0] sw_wdata = 32'h0, sw_rdata, v;
	logic [15:0] data_in, card_q, fl = 16'h5aa5, d;
	logic [1:0]  card_en, ln, fault_sel = 2'h0;
	logic [23:0] a, b;
	lfc_pins_t   pins;
	int          err_total = 0, checks = 0;
	logic [3:0]  ops [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7};
	logic [7:0]  codes [6] = '{8'hff, 8'h90, 8'h70, 8'h50, 8'hb0, 8'hd0};
	logic [7:0]  fmk [4] = '{8'h0, 8'h10, 8'h08, 8'h02};
	// a released lane shows a moving pattern, never the last value
	always @(posedge clk) fl <= ~fl;
	assign data_in = {pins.dout_en[1] ? pins.dout[15:8] : card_en[1] ? card_q[15:8] : fl[15:8],
		pins.dout_en[0] ? pins.dout[7:0] : card_en[0] ? card_q[7:0] : fl[7:0]};
	lfc_host #(.CARD_ADDR_BITS(23)) dut_u (.clk(clk), .rst(rst), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pins(pins),
		.data_in(data_in), .insert_detect_a_n(det_n), .insert_detect_b_n(det_n));
	lfc_card_model #(.ADDR_BITS(23), .MAKER_ID(MAKER)) card_u (.clk(clk), .pins(pins),
		.bus(data_in), .fault_sel(fault_sel), .busy_len(busy_len), .card_q(card_q),
		.card_en(card_en), .last_code(last_code));
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge clk);
		sw_addr <= ad;
		sw_wdata <= dt;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] ad);
		@(posedge clk);
		sw_addr <= ad;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1 v = sw_rdata;
	endtask : rd
	// one controller operation, waiting boundedly for busy to drop
	task automatic op(input logic [3:0] o, input logic [1:0] l, input logic [23:0] ad,
		input logic [15:0] dt);
		int n = 0;
		wr(REG_ADDR, {8'h0, ad});
		wr(REG_WDATA, {16'h0, dt});
		wr(REG_CTRL, {26'h0, l, o});
		v = 32'h1;
		while (v[STAT_BUSY_BIT] !== 1'b0) begin
			rd(REG_STAT);
			n++;
			if (n > 3000) begin
				err_total++;
				test_done();
			end
		end
	endtask : op
	task automatic rb(input logic [1:0] l, input logic [23:0] ad, input logic [15:0] exp);
		op(4'h8, l, ad, 16'h0);
		rd(REG_RDATA);
		chk(v, {16'h0, exp});
	endtask : rb
	function automatic logic [15:0] pw(input logic [1:0] l, input logic [15:0] w);
		return {l[1] ? w[15:8] : 8'hff, l[0] ? w[7:0] : 8'hff};
	endfunction : pw
	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		void'($urandom(22354));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(REG_STAT);
		chk(v, 32'h8);
		rb(2'h3, 24'h000123, 16'hffff);
		for (int i = 0; i < 6; i++) begin
			a = 24'($urandom) & 24'h7fffff;
			d = 16'($urandom);
			ln = 2'(i % 3 + 1);
			busy_len <= 8'($urandom_range(60, 2));
			op(4'h5, ln, a | {i[0], 23'h0}, d);
			rb(2'h3, a, 16'h8080);
			op(4'h0, 2'h3, 24'h0, 16'h0);
			rb(2'h3, a, pw(ln, d));
		end
		rb(2'h1, a, pw(ln, d) & 16'h00ff);
		a = 24'h050000 | 24'($urandom_range(65535));
		b = a + 24'h010000;
		op(4'h5, 2'h3, a, 16'h1234);
		op(4'h5, 2'h3, b, 16'h5678);
		op(4'h4, 2'h3, 24'h050000 | 24'($urandom_range(65535)), 16'h0);
		op(4'h0, 2'h3, 24'h0, 16'h0);
		rb(2'h3, a, 16'hffff);
		rb(2'h3, b, 16'h5678);
		op(4'h1, 2'h3, 24'h0, 16'h0);
		rd(REG_RDATA);
		chk(v, {16'h0, MAKER, MAKER});
		foreach (ops[i]) begin
			op(ops[i], 2'h3, 24'h0, 16'h0);
			chk(last_code, codes[i]);
		end
		rd(REG_STAT);
		chk(v[23:8], 16'h8080);
		for (int k = 1; k < 4; k++) begin
			fault_sel <= 2'(k);
			op(4'h5, 2'h3, 24'h000040, 16'h0f0f);
			fault_sel <= 2'h0;
			rd(REG_STAT);
			chk(v[23:0], {{2{8'h80 | fmk[k]}}, 8'h0a});
			op(4'h4, 2'h3, 24'h0, 16'h0);
			rd(REG_STAT);
			chk(v[2], 1'b1);
			op(4'h2, 2'h3, 24'h0, 16'h0);
			rd(REG_STAT);
			chk(v[23:8], {2{8'h80 | fmk[k]}});
			op(4'h3, 2'h3, 24'h0, 16'h0);
			op(4'h2, 2'h3, 24'h0, 16'h0);
			rd(REG_STAT);
			chk(v[23:0], 24'h808008);
		end
		op(4'h9, 2'h1, 24'h0, 16'h0);
		rd(REG_STAT);
		chk(v[23:8], 16'h0080);
		wr(REG_CTRL, 32'h8);
		rd(REG_STAT);
		chk(v[2], 1'b1);
		rd(8'h14);
		chk(v, 32'h0);
		@(posedge clk);
		det_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(REG_STAT);
		chk(v[3], 1'b0);
		test_done();
	end
endmodule : linear_flash_card_command_port_test
